// File: rtl/fmp_map.svh
// Summary of operation
// - cpu addresses 0x4000 to 0xffff are flash array, three 16k pages.
// - page select maps middle window 0x8000-0xbfff onto a physical page.
// - page 0x3e or 0x3f aliases the bottom or top fixed page.
// - 0x4000-0x7fff maps to 0x18000, 0xc000-0xffff maps to 0x1c000.
// - a global guard setting protects the whole array.
// - lower, higher and remaining areas are protected independently.
// - lower area grows up from array start, 1k to 8k.
// - higher area grows down from array end, 2k to 16k.
// - lower area may stay open while remaining addresses are guarded.
// - bytes 0xff00-0xff07 hold the backdoor key.
// - byte 0xff0d holds default guard, byte 0xff0f holds lock options.
// - sixteen register locations decode at module base plus 0x0 to 0xf.
`ifndef FMP_MAP_SVH
`define FMP_MAP_SVH
`define FMP_ARRAY_LO   16'h4000
`define FMP_FIX_LO_WIN 2'h1
`define FMP_PAGED_WIN  2'h2
`define FMP_FIX_HI_WIN 2'h3
`define FMP_PAGE_BOT   8'h3e
`define FMP_PAGE_TOP   8'h3f
`define FMP_PG_BOT     3'h6
`define FMP_PG_TOP     3'h7
`define FMP_LOW_UNIT   14'h0400
`define FMP_HIGH_UNIT  15'h0800
`define FMP_PAGE_SPAN  15'h4000
`define FMP_KEY_BASE   17'h1ff00
`define FMP_PROT_BYTE  17'h1ff0d
`define FMP_SEC_BYTE   17'h1ff0f
`define FMP_REG_BASE   16'h0100
`endif

// File: rtl/fmp_pkg.sv
package fmp_pkg;
   typedef enum logic [1:0] {
      FMP_AREA_NONE,
      FMP_AREA_LOW,
      FMP_AREA_MID,
      FMP_AREA_HIGH
   } fmp_area_e;
   typedef logic [16:0] fmp_arr_addr_t;
   typedef logic [2:0]  fmp_page_t;
endpackage : fmp_pkg

// File: rtl/fmp_chk_if.sv
`timescale 1ns/100ps
`default_nettype none
interface fmp_chk_if;
   import fmp_pkg::*;
   logic        in_array;
   fmp_page_t   page;
   logic [13:0] offset;
   logic [1:0]  low_size;
   logic [1:0]  high_size;
   fmp_area_e   area;
   modport chk (input in_array, page, offset, low_size, high_size,
                output area);
   modport user (output in_array, page, offset, low_size, high_size,
                 input area);
endinterface : fmp_chk_if
`default_nettype wire

// File: rtl/fmp_area_chk.sv
`timescale 1ns/100ps
`default_nettype none
`include "fmp_map.svh"
module fmp_area_chk
   import fmp_pkg::*;
(
   fmp_chk_if.chk c
);
   function automatic logic [13:0] low_limit(input logic [1:0] sz);
      low_limit = `FMP_LOW_UNIT << sz;
   endfunction : low_limit

   function automatic logic [14:0] high_start(input logic [1:0] sz);
      high_start = `FMP_PAGE_SPAN - (`FMP_HIGH_UNIT << sz);
   endfunction : high_start

   always_comb begin
      c.area = FMP_AREA_NONE;
      if (c.in_array) begin
         c.area = FMP_AREA_MID;
         if (c.page == `FMP_PG_BOT && c.offset < low_limit(c.low_size)) begin
            c.area = FMP_AREA_LOW;
         end
         if (c.page == `FMP_PG_TOP &&
             {1'b0, c.offset} >= high_start(c.high_size)) begin
            c.area = FMP_AREA_HIGH;
         end
      end
   end
endmodule : fmp_area_chk
`default_nettype wire

// File: rtl/fmp_decode.sv
`timescale 1ns/100ps
`default_nettype none
`include "fmp_map.svh"
module fmp_decode
   import fmp_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        arst_n,
   input  wire logic [15:0] cpu_addr,
   input  wire logic [7:0]  core_page_select,
   input  wire logic        op_req,
   input  wire logic        guard_global,
   input  wire logic        guard_low_en,
   input  wire logic [1:0]  guard_low_size,
   input  wire logic        guard_high_en,
   input  wire logic [1:0]  guard_high_size,
   input  wire logic        guard_mid_en,
   output var  logic        arr_hit,
   output var  fmp_arr_addr_t arr_addr,
   output var  fmp_area_e   area,
   output var  logic        reg_hit,
   output var  logic [3:0]  reg_idx,
   output var  logic        key_hit,
   output var  logic [2:0]  key_idx,
   output var  logic        guard_byte_hit,
   output var  logic        lock_byte_hit,
   output var  logic        op_blocked,
   output var  logic        op_granted
);
   fmp_chk_if c ();
   fmp_arr_addr_t arr_d;
   logic          hit_d;
   logic          prot_d;

   function automatic fmp_page_t page_of(input logic [1:0] win,
                                         input logic [7:0] psel);
      case (win)
         `FMP_FIX_LO_WIN: page_of = `FMP_PG_BOT;
         `FMP_PAGED_WIN:  page_of = psel[2:0];
         `FMP_FIX_HI_WIN: page_of = `FMP_PG_TOP;
         default:         page_of = `FMP_PG_BOT;
      endcase
   endfunction : page_of

   assign hit_d = cpu_addr >= `FMP_ARRAY_LO;
   assign arr_d = {page_of(cpu_addr[15:14], core_page_select),
                   cpu_addr[13:0]};

   assign c.in_array  = hit_d;
   assign c.page      = arr_d[16:14];
   assign c.offset    = arr_d[13:0];
   assign c.low_size  = guard_low_size;
   assign c.high_size = guard_high_size;

   fmp_area_chk u_chk (
      .c (c.chk)
   );

   always_comb begin
      prot_d = 1'b0;
      if (hit_d && guard_global) begin
         prot_d = 1'b1;
      end
      case (c.area)
         FMP_AREA_LOW:  prot_d = prot_d | guard_low_en;
         FMP_AREA_MID:  prot_d = prot_d | guard_mid_en;
         FMP_AREA_HIGH: prot_d = prot_d | guard_high_en;
         default:       prot_d = prot_d;
      endcase
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         arr_hit  <= 1'b0;
         arr_addr <= '0;
         area     <= FMP_AREA_NONE;
      end else begin
         arr_hit  <= hit_d;
         arr_addr <= arr_d;
         area     <= c.area;
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         key_hit        <= 1'b0;
         key_idx        <= 3'h0;
         guard_byte_hit <= 1'b0;
         lock_byte_hit  <= 1'b0;
      end else begin
         key_hit        <= hit_d && arr_d[16:3] == 14'(`FMP_KEY_BASE >> 3);
         key_idx        <= arr_d[2:0];
         guard_byte_hit <= hit_d && arr_d == `FMP_PROT_BYTE;
         lock_byte_hit  <= hit_d && arr_d == `FMP_SEC_BYTE;
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         reg_hit <= 1'b0;
         reg_idx <= 4'h0;
      end else begin
         reg_hit <= cpu_addr[15:4] == 12'(`FMP_REG_BASE >> 4);
         reg_idx <= cpu_addr[3:0];
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         op_blocked <= 1'b0;
         op_granted <= 1'b0;
      end else begin
         op_blocked <= op_req && hit_d && prot_d;
         op_granted <= op_req && hit_d && !prot_d;
      end
   end

   default clocking dc @(posedge sys_clk); endclocking
   default disable iff (!arst_n);

   a_array_hit_map: assert property (
      cpu_addr >= 16'h4000 |=> arr_hit)
      else $error("array address not flagged");
   a_array_miss_map: assert property (
      cpu_addr < 16'h4000 |=> !arr_hit && !op_blocked && !op_granted)
      else $error("non array address flagged");
   a_fixed_low_map: assert property (
      cpu_addr[15:14] == 2'h1 |=> arr_addr == {3'h6, $past(cpu_addr[13:0])})
      else $error("low fixed page mistranslated");
   a_fixed_high_map: assert property (
      cpu_addr[15:14] == 2'h3 |=> arr_addr == {3'h7, $past(cpu_addr[13:0])})
      else $error("high fixed page mistranslated");
   a_paged_win_map: assert property (
      cpu_addr[15:14] == 2'h2
      |=> arr_addr[16:14] == $past(core_page_select[2:0]))
      else $error("paged window ignores page select");
   a_page_alias_map: assert property (
      cpu_addr[15:14] == 2'h2 && core_page_select == 8'h3e
      ##1 cpu_addr[15:14] == 2'h1 && cpu_addr[13:0] == $past(cpu_addr[13:0])
      |=> arr_addr == $past(arr_addr))
      else $error("page alias differs from fixed page");
   a_global_guard_blk: assert property (
      op_req && guard_global && cpu_addr >= 16'h4000 |=> op_blocked)
      else $error("global guard not honoured");
   a_low_area_blk: assert property (
      op_req && guard_low_en && cpu_addr[15:10] == 6'h10
      |=> op_blocked && area == FMP_AREA_LOW)
      else $error("lower area not guarded");
   a_high_area_blk: assert property (
      op_req && guard_high_en && cpu_addr[15:11] == 5'h1f
      |=> op_blocked && area == FMP_AREA_HIGH)
      else $error("higher area not guarded");
   a_low_open_mid: assert property (
      op_req && !guard_global && !guard_low_en && guard_mid_en
      && cpu_addr[15:10] == 6'h10 |=> op_granted && !op_blocked)
      else $error("open lower area blocked");
   a_mid_area_blk: assert property (
      op_req && guard_mid_en && cpu_addr[15:12] == 4'h6 |=> op_blocked)
      else $error("remaining area not guarded");
   a_backdoor_key: assert property (
      cpu_addr[15:3] == 13'h1fe0
      |=> key_hit && key_idx == $past(cpu_addr[2:0]))
      else $error("key byte not decoded");
   a_config_bytes: assert property (
      cpu_addr == 16'hff0d ##1 cpu_addr == 16'hff0f
      |-> guard_byte_hit ##1 lock_byte_hit)
      else $error("config byte not decoded");
   a_reg_block: assert property (
      cpu_addr[15:4] == 12'h010
      |=> reg_hit && reg_idx == $past(cpu_addr[3:0]))
      else $error("register location not decoded");
   a_no_req_quiet: assert property (
      !op_req |=> !op_blocked && !op_granted)
      else $error("operation outputs without request");
   a_op_grant_open: assert property (
      op_req && cpu_addr >= 16'h4000 && !guard_global && !guard_low_en
      && !guard_mid_en && !guard_high_en |=> op_granted && !op_blocked)
      else $error("unguarded operation not granted");
   a_area_none_out: assert property (
      cpu_addr < 16'h4000 |=> area == FMP_AREA_NONE)
      else $error("area given outside array");
   a_alias_bot_map: assert property (
      cpu_addr[15:14] == 2'h2 && core_page_select == 8'h3e
      |=> arr_addr == {3'h6, $past(cpu_addr[13:0])})
      else $error("bottom page alias mistranslated");
   a_alias_top_map: assert property (
      cpu_addr[15:14] == 2'h2 && core_page_select == 8'h3f
      |=> arr_addr == {3'h7, $past(cpu_addr[13:0])})
      else $error("top page alias mistranslated");
   a_low_size_edge: assert property (
      op_req && guard_low_en && !guard_global && !guard_mid_en
      && cpu_addr[15:14] == 2'h1
      && cpu_addr[13:0] == (14'h0400 << guard_low_size)
      |=> op_granted && area == FMP_AREA_MID)
      else $error("lower area reaches past its end");
   a_low_alias_blk: assert property (
      op_req && guard_low_en && core_page_select == 8'h3e
      && cpu_addr[15:10] == 6'h20 |=> op_blocked && area == FMP_AREA_LOW)
      else $error("lower area mirror not guarded");
   a_high_size_edge: assert property (
      op_req && guard_high_en && !guard_global && !guard_mid_en
      && cpu_addr[15:14] == 2'h3
      && {1'b0, cpu_addr[13:0]} == 15'h3fff - (15'h0800 << guard_high_size)
      |=> op_granted && area == FMP_AREA_MID)
      else $error("higher area reaches below its start");
   a_high_alias_blk: assert property (
      op_req && guard_high_en && core_page_select == 8'h3f
      && cpu_addr[15:11] == 5'h17 |=> op_blocked && area == FMP_AREA_HIGH)
      else $error("higher area mirror not guarded");
   a_key_range_miss: assert property (
      cpu_addr[15:3] == 13'h1fe1 |=> !key_hit)
      else $error("reserved byte taken as key");
   a_guard_byte_only: assert property (
      cpu_addr[15:14] == 2'h3 && cpu_addr[13:0] != 14'h3f0d
      |=> !guard_byte_hit)
      else $error("guard byte decoded at wrong address");
   a_lock_byte_only: assert property (
      cpu_addr[15:14] == 2'h3 && cpu_addr[13:0] != 14'h3f0f
      |=> !lock_byte_hit)
      else $error("lock byte decoded at wrong address");
   a_reg_block_miss: assert property (
      cpu_addr[15:4] != 12'h010 |=> !reg_hit)
      else $error("register location decoded outside block");
endmodule : fmp_decode
`default_nettype wire

// File: verif/fmp_cpu_model.sv
`timescale 1ns/100ps
`default_nettype none
module fmp_cpu_model (
   input  wire logic        sys_clk,
   output var  logic [15:0] cpu_addr,
   output var  logic [7:0]  core_page_select,
   output var  logic        op_req
);
   initial begin
      cpu_addr = 16'h0000;
      core_page_select = 8'h00;
      op_req = 1'b0;
   end
   task automatic issue(input logic [15:0] a, input logic [7:0] p,
                        input logic r);
      @(negedge sys_clk);
      cpu_addr <= a;
      core_page_select <= p;
      op_req <= r;
   endtask : issue
endmodule : fmp_cpu_model
`default_nettype wire

// File: verif/flash_map_protect_decode_tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
   n_fail++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module flash_map_protect_decode_tb;
   import fmp_pkg::*;
   logic sys_clk = 1'b0, arst_n = 1'b0, gg = 1'b0, gl = 1'b0, gh = 1'b0;
   logic gm = 1'b0;
   logic [1:0] ls = 2'h0, hs = 2'h0;
   logic [15:0] ca;
   logic [7:0] ps;
   logic rq, ah, rh, kh, gb, lb, ob, og;
   fmp_arr_addr_t aa;
   fmp_area_e ar;
   logic [3:0] ri;
   logic [2:0] ki;
   int n_fail = 0, comparisons = 0, cyc = 0;
   always #50 sys_clk = ~sys_clk;
   fmp_cpu_model cpu (.sys_clk(sys_clk), .cpu_addr(ca),
      .core_page_select(ps), .op_req(rq));
   fmp_decode uut (.sys_clk(sys_clk), .arst_n(arst_n), .cpu_addr(ca),
      .core_page_select(ps), .op_req(rq), .guard_global(gg),
      .guard_low_en(gl), .guard_low_size(ls), .guard_high_en(gh),
      .guard_high_size(hs), .guard_mid_en(gm), .arr_hit(ah),
      .arr_addr(aa), .area(ar), .reg_hit(rh), .reg_idx(ri),
      .key_hit(kh), .key_idx(ki), .guard_byte_hit(gb),
      .lock_byte_hit(lb), .op_blocked(ob), .op_granted(og));
   task automatic final_report;
      if (n_fail == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : final_report
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 5000) begin
         n_fail++;
         final_report();
      end
   end
   task automatic go(input logic [15:0] a, input logic [7:0] p,
                     input logic r);
      cpu.issue(a, p, r);
      @(negedge sys_clk);
   endtask : go
   task automatic op(input logic [15:0] a, input logic [7:0] p,
                     input logic b);
      go(a, p, 1'b1);
      `CHK("op_blocked", b, ob)
      `CHK("op_granted", !b, og)
   endtask : op
   task automatic t_map;
      logic [15:0] al[6] = '{16'h4000, 16'h7fff, 16'h8000, 16'hbfff,
                             16'hc000, 16'hffff};
      logic [7:0] pl[5] = '{8'h00, 8'h01, 8'h05, 8'h3e, 8'h3f};
      logic [16:0] e;
      foreach (pl[j]) foreach (al[i]) begin
         go(al[i], pl[j], 1'b0);
         e = (al[i][15:14] == 2'h1) ? {3'h6, al[i][13:0]} :
             (al[i][15:14] == 2'h2) ? {pl[j][2:0], al[i][13:0]} :
             {3'h7, al[i][13:0]};
         `CHK("arr_hit", 1'b1, ah)
         `CHK("arr_addr", e, aa)
      end
      go(16'h3fff, 8'h00, 1'b1);
      `CHK("arr_hit", 1'b0, ah)
      `CHK("op_outs", 2'b00, {ob, og})
      `CHK("area", FMP_AREA_NONE, ar)
      go(16'h8123, 8'h3e, 1'b0);
      `CHK("alias_mid", 17'h18123, aa)
      go(16'h4123, 8'h3e, 1'b0);
      `CHK("alias_low", 17'h18123, aa)
   endtask : t_map
   task automatic t_areas;
      logic [15:0] t;
      gl = 1'b1;
      for (int s = 0; s < 4; s++) begin
         ls = s[1:0];
         t = 16'h4000 + (16'h0400 << s) - 16'h0001;
         op(t, 8'h00, 1'b1);
         `CHK("area", FMP_AREA_LOW, ar)
         op(t + 16'h0001, 8'h00, 1'b0);
         op(t + 16'h4000, 8'h3e, 1'b1);
      end
      gl = 1'b0;
      gh = 1'b1;
      for (int s = 0; s < 4; s++) begin
         hs = s[1:0];
         t = 16'h0000 - (16'h0800 << s);
         op(t, 8'h00, 1'b1);
         `CHK("area", FMP_AREA_HIGH, ar)
         op(t - 16'h0001, 8'h00, 1'b0);
         op(t - 16'h4000, 8'h3f, 1'b1);
      end
      gh = 1'b0;
      gm = 1'b1;
      ls = 2'h0;
      hs = 2'h0;
      op(16'h4000, 8'h00, 1'b0);
      op(16'h4400, 8'h00, 1'b1);
      op(16'h6000, 8'h00, 1'b1);
      `CHK("area", FMP_AREA_MID, ar)
      op(16'h8000, 8'h02, 1'b1);
      op(16'hf7ff, 8'h00, 1'b1);
      op(16'hffff, 8'h00, 1'b0);
      gm = 1'b0;
      gg = 1'b1;
      op(16'h4000, 8'h00, 1'b1);
      op(16'h8000, 8'h05, 1'b1);
      op(16'hffff, 8'h00, 1'b1);
      gg = 1'b0;
      op(16'h9000, 8'h04, 1'b0);
   endtask : t_areas
   task automatic t_cfg;
      for (int i = 0; i < 9; i++) begin
         go(16'hff00 + i[15:0], 8'h00, 1'b0);
         `CHK("key_hit", i < 8, kh)
         if (i < 8) `CHK("key_idx", i[2:0], ki)
      end
      go(16'hff0d, 8'h00, 1'b0);
      `CHK("bytes_d", 2'b10, {gb, lb})
      go(16'hff0f, 8'h00, 1'b0);
      `CHK("bytes_f", 2'b01, {gb, lb})
   endtask : t_cfg
   task automatic t_reg;
      for (int i = 0; i < 18; i++) begin
         go(16'h00ff + i[15:0], 8'h00, 1'b0);
         `CHK("reg_hit", i > 0 && i < 17, rh)
         if (i > 0 && i < 17) `CHK("reg_idx", i[3:0] - 4'h1, ri)
      end
   endtask : t_reg
   initial begin
      repeat (16) @(posedge sys_clk);
      @(negedge sys_clk);
      arst_n = 1'b1;
      t_map();
      t_areas();
      t_cfg();
      t_reg();
      final_report();
   end
endmodule : flash_map_protect_decode_tb
`default_nettype wire
